// ==== include/cprs_pkg.sv ====
// Constants and types for the CPU register state block.
// Assumes a single clock domain and a synchronous reset.
package cprs_pkg;
   localparam int PC_W = 20;
   localparam int SP_W = 16;
   localparam logic [7:0] PSW_RESET = 8'h06;
   localparam logic [7:0] MIRROR_RESET = 8'h00;
   localparam logic [3:0] PC_TOP_RESET = 4'h0;
   // Status word and mirror control bit positions
   localparam int IE_B = 7;
   localparam int Z_B = 6;
   localparam int BANK_SELECT_HIGH_B = 5;
   localparam int AC_B = 4;
   localparam int BANK_SELECT_LOW_B = 3;
   localparam int SERVICE_LEVEL_HIGH_B = 2;
   localparam int SERVICE_LEVEL_LOW_B = 1;
   localparam int CY_B = 0;
   localparam int MAA_B = 0;
   // Data memory map and nibble limit
   localparam logic [19:0] GPR_BASE = 20'hFFEE0;
   localparam logic [19:0] GPR_LAST = 20'hFFEFF;
   localparam logic [19:0] RAM_LAST = 20'hFFEFF;
   localparam logic [19:0] RAM_SMALL_BASE = 20'hFFB00;
   localparam logic [19:0] RAM_LARGE_BASE = 20'hFF900;
   localparam logic [19:0] SFR2_BASE = 20'hF0000;
   localparam logic [19:0] SFR2_LAST = 20'hF07FF;
   localparam int GPR_BYTES = 32;
   localparam logic [3:0] NIBBLE_MAX = 4'hF;
   // Register port indexes
   localparam logic [3:0] REG_PC = 4'h0;
   localparam logic [3:0] REG_PSW = 4'h1;
   localparam logic [3:0] REG_SP = 4'h2;
   localparam logic [3:0] REG_MIRROR = 4'h3;
   typedef enum logic [1:0] {
      AREA_OTHER = 2'h0,
      AREA_RAM = 2'h1,
      AREA_GPR = 2'h3,
      AREA_SFR2 = 2'h2
   } cprs_area_t;
endpackage

// ==== src/cprs_core_state.sv ====
// Program counter, status word, stack pointer, register banks.
// Assumes the core drives one-cycle strobes on clk_sys.
`timescale 1ns/10ps
// How it works
// - 20-bit counter steps by length or loads
// - Reset loads vector bytes, top nibble zero
// - Status word flags, reset value 06H
// - Status pushed on acknowledge/push, popped on returns
// - Gate flag low rejects all maskable requests
// - Mask-all or acknowledge clears gate, unmask sets
// - Zero flag follows zero or equal result
// - Two-bit bank select written by bank switch
// - Half carry from carry or borrow at bit 3
// - Requests below in-service level are refused
// - Carry holds overflow, shift-out, bit accumulator
// - Stack pointer predecrements on write, postincrements
// - Stack pointer undefined after reset
// - Four banks of eight bytes in RAM window
// - Bytes usable singly or as four pairs
// - Internal RAM ends FFEFFH, two sizes
// - Second peripheral area costs one extra byte
// - Mirror control register resets to 00H
module cprs_core_state #(
   parameter bit LARGE_RAM = 1'b1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [19:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [19:0] reg_rdata,
   input wire logic [7:0] vector_lo,
   input wire logic [7:0] vector_hi,
   input wire logic pc_step,
   input wire logic [2:0] pc_len,
   input wire logic pc_load,
   input wire logic [19:0] pc_target,
   input wire logic alu_go,
   input wire logic alu_sub,
   input wire logic [7:0] alu_a,
   input wire logic [7:0] alu_b,
   output logic [7:0] alu_result,
   input wire logic rot_go,
   input wire logic rot_out_bit,
   input wire logic bit_go,
   input wire logic bit_val,
   input wire logic mask_all_instr,
   input wire logic unmask_all_instr,
   input wire logic bank_switch_instr,
   input wire logic [1:0] bank_sel,
   input wire logic irq_req,
   input wire logic irq_masked,
   input wire logic [1:0] irq_prio,
   output logic irq_ack,
   input wire logic push_status,
   input wire logic restore_go,
   input wire logic [7:0] restore_data,
   output logic stk_we,
   output logic [15:0] stk_addr,
   output logic [7:0] stk_wdata,
   input wire logic gpr_pair_mode,
   input wire logic [2:0] gpr_sel,
   input wire logic gpr_we,
   input wire logic [15:0] gpr_wdata,
   output logic [15:0] gpr_rdata,
   input wire logic [19:0] mem_addr,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic [1:0] mem_area,
   output logic mem_extra_byte,
   output logic [1:0] fetch_area,
   output logic [19:0] program_counter,
   output logic [7:0] status_word,
   output logic mirror_active
);
   localparam logic [19:0] RAM_BASE = LARGE_RAM ?
      cprs_pkg::RAM_LARGE_BASE : cprs_pkg::RAM_SMALL_BASE;

   logic [15:0] stack_pointer;
   logic [7:0] mirror_control_register;
   logic [7:0] gpr_mem [cprs_pkg::GPR_BYTES];
   logic accept;
   logic stack_push;
   logic [1:0] isp;
   logic [8:0] next_sum;
   logic [4:0] next_low;
   logic [4:0] lo_idx;
   logic [4:0] hi_idx;
   logic [4:0] mem_idx;
   logic sw_pc;
   logic sw_psw;
   logic sw_sp;

   // Memory map decode
   function automatic cprs_pkg::cprs_area_t area_of(
      input logic [19:0] a);
      if (a >= cprs_pkg::GPR_BASE && a <= cprs_pkg::GPR_LAST) begin
         area_of = cprs_pkg::AREA_GPR;
      end else if (a >= RAM_BASE && a <= cprs_pkg::RAM_LAST) begin
         area_of = cprs_pkg::AREA_RAM;
      end else if (a >= cprs_pkg::SFR2_BASE &&
                   a <= cprs_pkg::SFR2_LAST) begin
         area_of = cprs_pkg::AREA_SFR2;
      end else begin
         area_of = cprs_pkg::AREA_OTHER;
      end
   endfunction

   // Bank and byte to array index, bank 0 on top
   function automatic logic [4:0] gpr_index(
      input logic [1:0] bank, input logic [2:0] idx);
      gpr_index = {~bank, idx};
   endfunction

   assign isp = {status_word[cprs_pkg::SERVICE_LEVEL_HIGH_B],
                 status_word[cprs_pkg::SERVICE_LEVEL_LOW_B]};
   assign accept = irq_req && !irq_masked &&
      status_word[cprs_pkg::IE_B] && (irq_prio <= isp);
   assign stack_push = accept || push_status;
   assign sw_pc = reg_wr && reg_addr == cprs_pkg::REG_PC;
   assign sw_psw = reg_wr && reg_addr == cprs_pkg::REG_PSW;
   assign sw_sp = reg_wr && reg_addr == cprs_pkg::REG_SP;
   assign next_sum = alu_sub ? {1'b0, alu_a} - {1'b0, alu_b}
                             : {1'b0, alu_a} + {1'b0, alu_b};
   assign next_low = alu_sub ? {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]}
                             : {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
   assign lo_idx = gpr_index(
      {status_word[cprs_pkg::BANK_SELECT_HIGH_B], status_word[cprs_pkg::BANK_SELECT_LOW_B]},
      gpr_pair_mode ? {gpr_sel[1:0], 1'b0} : gpr_sel);
   assign hi_idx = gpr_index(
      {status_word[cprs_pkg::BANK_SELECT_HIGH_B], status_word[cprs_pkg::BANK_SELECT_LOW_B]},
      {gpr_sel[1:0], 1'b1});
   assign mem_idx = 5'(mem_addr - cprs_pkg::GPR_BASE);

   // Program counter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         program_counter <= {cprs_pkg::PC_TOP_RESET,
                             vector_hi, vector_lo};
      end else if (sw_pc) begin
         program_counter <= reg_wdata;
      end else if (pc_load) begin
         program_counter <= pc_target;
      end else if (pc_step) begin
         program_counter <= program_counter + 20'(pc_len);
      end
   end

   // Status word, later assignments take priority
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         status_word <= cprs_pkg::PSW_RESET;
      end else begin
         if (alu_go) begin
            status_word[cprs_pkg::Z_B] <= next_sum[7:0] == 8'h00;
            status_word[cprs_pkg::AC_B] <= next_low[4];
            status_word[cprs_pkg::CY_B] <= next_sum[8];
         end
         if (rot_go) begin
            status_word[cprs_pkg::CY_B] <= rot_out_bit;
         end
         if (bit_go) begin
            status_word[cprs_pkg::CY_B] <= bit_val;
         end
         if (unmask_all_instr) begin
            status_word[cprs_pkg::IE_B] <= 1'b1;
         end
         if (mask_all_instr) begin
            status_word[cprs_pkg::IE_B] <= 1'b0;
         end
         if (bank_switch_instr) begin
            status_word[cprs_pkg::BANK_SELECT_HIGH_B] <= bank_sel[1];
            status_word[cprs_pkg::BANK_SELECT_LOW_B] <= bank_sel[0];
         end
         if (accept) begin
            status_word[cprs_pkg::IE_B] <= 1'b0;
            status_word[cprs_pkg::SERVICE_LEVEL_HIGH_B] <= irq_prio[1];
            status_word[cprs_pkg::SERVICE_LEVEL_LOW_B] <= irq_prio[0];
         end
         if (restore_go) begin
            status_word <= restore_data;
         end
         if (sw_psw) begin
            status_word <= reg_wdata[7:0];
         end
      end
   end

   // Stack pointer, left unset by reset
   always_ff @(posedge clk_sys) begin
      if (sw_sp) begin
         stack_pointer <= reg_wdata[15:0];
      end else if (stack_push) begin
         stack_pointer <= stack_pointer - 16'h0001;
      end else if (restore_go) begin
         stack_pointer <= stack_pointer + 16'h0001;
      end
   end

   // Status push onto stack
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stk_we <= 1'b0;
         stk_addr <= 16'h0000;
         stk_wdata <= 8'h00;
         irq_ack <= 1'b0;
      end else begin
         stk_we <= stack_push && !sw_sp;
         stk_addr <= stack_pointer - 16'h0001;
         stk_wdata <= status_word;
         irq_ack <= accept;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         alu_result <= 8'h00;
      end else if (alu_go) begin
         alu_result <= next_sum[7:0];
      end
   end

   // Shared register bank storage
   always_ff @(posedge clk_sys) begin
      if (gpr_we) begin
         gpr_mem[lo_idx] <= gpr_wdata[7:0];
         if (gpr_pair_mode) begin
            gpr_mem[hi_idx] <= gpr_wdata[15:8];
         end
      end
      if (mem_we && area_of(mem_addr) == cprs_pkg::AREA_GPR) begin
         gpr_mem[mem_idx] <= mem_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gpr_rdata <= 16'h0000;
         mem_rdata <= 8'h00;
      end else begin
         gpr_rdata <= gpr_pair_mode ?
            {gpr_mem[hi_idx], gpr_mem[lo_idx]} :
            {8'h00, gpr_mem[lo_idx]};
         mem_rdata <= area_of(mem_addr) == cprs_pkg::AREA_GPR ?
            gpr_mem[mem_idx] : 8'h00;
      end
   end

   // Area decode for data access and fetch
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mem_area <= cprs_pkg::AREA_OTHER;
         mem_extra_byte <= 1'b0;
         fetch_area <= cprs_pkg::AREA_OTHER;
      end else begin
         mem_area <= area_of(mem_addr);
         mem_extra_byte <= area_of(mem_addr) ==
            cprs_pkg::AREA_SFR2;
         fetch_area <= area_of(program_counter);
      end
   end

   // Mirror control
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mirror_control_register <= cprs_pkg::MIRROR_RESET;
         mirror_active <= 1'b1;
      end else begin
         if (reg_wr && reg_addr == cprs_pkg::REG_MIRROR) begin
            mirror_control_register <= reg_wdata[7:0];
         end
         mirror_active <=
            !mirror_control_register[cprs_pkg::MAA_B];
      end
   end

   // Register port read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= 20'h00000;
      end else if (reg_rd) begin
         case (reg_addr)
            cprs_pkg::REG_PC: reg_rdata <= program_counter;
            cprs_pkg::REG_PSW: reg_rdata <= {12'h000, status_word};
            cprs_pkg::REG_SP: reg_rdata <= {4'h0, stack_pointer};
            cprs_pkg::REG_MIRROR: begin
               reg_rdata <= {12'h000, mirror_control_register};
            end
            default: reg_rdata <= 20'h00000;
         endcase
      end else begin
         reg_rdata <= 20'h00000;
      end
   end

   // Checks
   logic psw_quiet;
   assign psw_quiet = !restore_go && !sw_psw;

   sequence step_only_s;
      pc_step && !pc_load && !sw_pc;
   endsequence

   sequence ack_s;
      accept && psw_quiet;
   endsequence

   pc_step_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      step_only_s |=> program_counter ==
         $past(program_counter) + 20'($past(pc_len)))
      else $error("pc step wrong");

   pc_reset_a: assert property (
      @(posedge clk_sys) $fell(reset) |->
      program_counter == {cprs_pkg::PC_TOP_RESET,
         $past(vector_hi), $past(vector_lo)})
      else $error("pc reset load wrong");

   psw_reset_a: assert property (
      @(posedge clk_sys) $fell(reset) |->
      status_word == cprs_pkg::PSW_RESET)
      else $error("status reset wrong");

   ack_gate_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      irq_ack |-> $past(status_word[cprs_pkg::IE_B]) &&
         $past(irq_prio) <= $past(isp))
      else $error("request taken while gated");

   ack_clear_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      ack_s |=> !status_word[cprs_pkg::IE_B] && irq_ack ##1 !irq_ack)
      else $error("gate not cleared on ack");

   ack_push_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      (ack_s and !sw_sp) |=> stk_we && stk_wdata == $past(status_word))
      else $error("status not pushed");

   zero_flag_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      alu_go && psw_quiet |=> status_word[cprs_pkg::Z_B] ==
         (alu_result == 8'h00))
      else $error("zero flag wrong");

   half_carry_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      alu_go && !alu_sub && psw_quiet |=>
      status_word[cprs_pkg::AC_B] == ({1'b0, $past(alu_a[3:0])} +
         {1'b0, $past(alu_b[3:0])} > {1'b0, cprs_pkg::NIBBLE_MAX}))
      else $error("half carry wrong");

   bank_sel_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      bank_switch_instr && psw_quiet |=>
      {status_word[cprs_pkg::BANK_SELECT_HIGH_B], status_word[cprs_pkg::BANK_SELECT_LOW_B]}
         == $past(bank_sel))
      else $error("bank select wrong");

   stack_dec_a: assert property (
      @(posedge clk_sys) disable iff (reset)
      stk_we |-> stk_addr == stack_pointer)
      else $error("stack not predecremented");

   mirror_reset_a: assert property (
      @(posedge clk_sys) $fell(reset) |->
      mirror_control_register == cprs_pkg::MIRROR_RESET ##1
      mirror_active)
      else $error("mirror reset wrong");
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the CPU register state block.
// Assumes cprs_pkg is compiled first; the bench drives every input.
`timescale 1ns/10ps
module tb_top;
   logic clk_sys = 1'b0;
   logic reset;
   logic [19:0] reg_wdata, reg_rdata, pc_target, mem_addr, program_counter;
   logic [15:0] gpr_wdata, gpr_rdata, stk_addr, v, sp;
   logic [7:0] vector_lo, vector_hi, alu_a, alu_b, alu_result, restore_data;
   logic [7:0] stk_wdata, mem_wdata, mem_rdata, status_word, a, b, r, d, ps;
   logic [3:0] reg_addr;
   logic [2:0] pc_len, gpr_sel, pl;
   logic [1:0] bank_sel, irq_prio, mem_area, fetch_area;
   logic reg_wr, reg_rd, pc_step, pc_load, alu_go, alu_sub, rot_go, c, h;
   logic rot_out_bit, bit_go, bit_val, mask_all_instr, unmask_all_instr;
   logic bank_switch_instr, irq_req, irq_masked, irq_ack, push_status;
   logic restore_go, stk_we, gpr_pair_mode, gpr_we, mem_we, mirror_active;
   logic [19:0] pe;
   logic [11:0] e;
   logic rd_pend = 1'b0;
   logic [23:0] rd_q[$], stk_q[$];
   int n_fail = 0, cmp_count = 0, cycles = 0, seed;
   logic [19:0] adr_t [9] = '{20'hFF900, 20'hFF8FF, 20'hFFEE0, 20'hFFEFF,
      20'hFFEDF, 20'hFFF00, 20'hF0000, 20'hF07FF, 20'hF0800};
   logic [2:0] are_t [9] = '{3'h2, 3'h0, 3'h6, 3'h6, 3'h2, 3'h0, 3'h5,
      3'h5, 3'h0};
   // Masked, priority, status before, accepted
   logic [11:0] irq_t [5] = '{{1'b0, 2'h3, 8'h84, 1'b0},
      {1'b1, 2'h0, 8'h84, 1'b0}, {1'b0, 2'h0, 8'h04, 1'b0},
      {1'b0, 2'h1, 8'h84, 1'b1}, {1'b0, 2'h2, 8'h84, 1'b1}};

   logic c_extra;

   cprs_core_state #(.LARGE_RAM(1'b1)) i_dut (
      .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .vector_lo, .vector_hi, .pc_step, .pc_len, .pc_load, .pc_target,
      .alu_go, .alu_sub, .alu_a, .alu_b, .alu_result, .rot_go, .rot_out_bit,
      .bit_go, .bit_val, .mask_all_instr, .unmask_all_instr,
      .bank_switch_instr, .bank_sel, .irq_req, .irq_masked, .irq_prio,
      .irq_ack, .push_status, .restore_go, .restore_data, .stk_we,
      .stk_addr, .stk_wdata, .gpr_pair_mode, .gpr_sel, .gpr_we, .gpr_wdata,
      .gpr_rdata, .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .mem_area,
      .mem_extra_byte(c_extra), .fetch_area, .program_counter, .status_word,
      .mirror_active
   );

   always #2.5 clk_sys = ~clk_sys;

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Ends every strobe one cycle after it was raised
   task automatic fin;
      @(posedge clk_sys);
      {reg_wr, reg_rd, pc_step, pc_load, alu_go, rot_go, bit_go} <= '0;
      {mask_all_instr, unmask_all_instr, bank_switch_instr} <= '0;
      {irq_req, push_status, restore_go, gpr_we, mem_we} <= '0;
      #1;
   endtask

   task automatic wr(input logic [3:0] ad, input logic [19:0] dt);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= dt;
      fin();
   endtask

   task automatic rd(input logic [3:0] ad, input logic [19:0] ex);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      rd_q.push_back({4'h0, ex});
      fin();
   endtask

   // Waits one edge so registered outputs show the new inputs
   task automatic settle;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic gchk(input logic pm, input logic [2:0] sl,
      input logic [15:0] ex);
      @(posedge clk_sys);
      gpr_pair_mode <= pm;
      gpr_sel <= sl;
      @(posedge clk_sys);
      #1;
      chk(24'(gpr_rdata), 24'(ex));
   endtask

   // Result watchers: read data and stack writes against the notes
   always @(posedge clk_sys) rd_pend <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_pend === 1'b1)
         chk({4'h0, reg_rdata}, rd_q.pop_front());
      if (stk_we === 1'b1)
         chk({stk_addr, stk_wdata}, stk_q.pop_front());
   end

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end

   initial begin
      seed = $urandom(32'h30cf);
      {reg_wr, reg_rd, pc_step, pc_load, alu_go, alu_sub, rot_go} = '0;
      {rot_out_bit, bit_go, bit_val, mask_all_instr, unmask_all_instr} = '0;
      {bank_switch_instr, irq_req, irq_masked, push_status, restore_go} = '0;
      {gpr_pair_mode, gpr_we, mem_we, bank_sel, irq_prio, pc_len} = '0;
      {reg_addr, reg_wdata, pc_target, alu_a, alu_b, restore_data} = '0;
      {gpr_sel, gpr_wdata, mem_addr, mem_wdata} = '0;
      vector_lo = 8'($urandom);
      vector_hi = 8'($urandom);
      reset = 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk(24'(program_counter), {8'h00, vector_hi, vector_lo});
      chk(24'(status_word), 24'h000006);
      chk(24'(mirror_active), 24'h000001);
      rd(cprs_pkg::REG_MIRROR, 20'h00000);
      rd(cprs_pkg::REG_PSW, 20'h00006);
      rd(4'h9, 20'h00000);
      // Counter wraps at 20 bits; load beats step on the last pass
      wr(cprs_pkg::REG_PC, 20'hFFFFE);
      pe = 20'hFFFFE;
      for (int i = 0; i < 6; i++) begin
         pl = 3'($urandom_range(1, 4));
         @(posedge clk_sys);
         pc_step <= 1'b1;
         pc_len <= pl;
         pc_load <= (i == 5);
         pc_target <= 20'hFFE00;
         fin();
         pe = (i == 5) ? 20'hFFE00 : pe + 20'(pl);
         chk(24'(program_counter), 24'(pe));
      end
      settle();
      chk(24'(fetch_area), 24'(cprs_pkg::AREA_RAM));
      rd(cprs_pkg::REG_PC, pe);
      for (int i = 0; i < 16; i++) begin
         a = 8'($urandom);
         b = (i == 3) ? a : (i == 4) ? 8'h00 - a : 8'($urandom);
         @(posedge clk_sys);
         alu_go <= 1'b1;
         alu_sub <= i[0];
         alu_a <= a;
         alu_b <= b;
         fin();
         {c, r} = i[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
         h = i[0] ? a[3:0] < b[3:0] : {1'b0, a[3:0]} + b[3:0] > 5'h0F;
         chk(24'(alu_result), 24'(r));
         chk(24'({status_word[cprs_pkg::Z_B],
            status_word[cprs_pkg::AC_B], status_word[cprs_pkg::CY_B]}),
            24'({r == 8'h00, h, c}));
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         rot_go <= ~i[1];
         bit_go <= i[1];
         rot_out_bit <= i[0];
         bit_val <= i[0];
         fin();
         chk(24'(status_word[cprs_pkg::CY_B]), 24'(i[0]));
      end
      // Mask and unmask pairs: unmask, both, unmask, mask
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         {mask_all_instr, unmask_all_instr} <=
            2'(8'b01_11_01_10 >> (6 - 2 * i));
         fin();
         chk(24'(status_word[cprs_pkg::IE_B]), 24'(i[0] == 1'b0));
      end
      for (int k = 0; k < 4; k++) begin
         d = 8'($urandom);
         @(posedge clk_sys);
         bank_switch_instr <= 1'b1;
         bank_sel <= 2'(k);
         fin();
         chk(24'({status_word[cprs_pkg::BANK_SELECT_HIGH_B],
            status_word[cprs_pkg::BANK_SELECT_LOW_B]}), 24'(k));
         @(posedge clk_sys);
         gpr_we <= 1'b1;
         gpr_pair_mode <= 1'b0;
         gpr_sel <= 3'(k + 3);
         gpr_wdata <= {8'h00, d};
         mem_addr <= cprs_pkg::GPR_BASE + 20'((3 - k) * 8 + k + 3);
         fin();
         settle();
         chk(24'(mem_rdata), 24'(d));
      end
      v = 16'($urandom);
      @(posedge clk_sys);
      gpr_we <= 1'b1;
      gpr_pair_mode <= 1'b1;
      gpr_sel <= 3'h2;
      gpr_wdata <= v;
      fin();
      @(posedge clk_sys);
      mem_we <= 1'b1;
      mem_addr <= cprs_pkg::GPR_BASE;
      mem_wdata <= d;
      fin();
      gchk(1'b0, 3'h4, {8'h00, v[7:0]});
      gchk(1'b0, 3'h5, {8'h00, v[15:8]});
      gchk(1'b1, 3'h2, v);
      gchk(1'b0, 3'h0, {8'h00, d});
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys);
         mem_addr <= adr_t[i];
         settle();
         chk(24'({mem_area, c_extra}), 24'(are_t[i]));
      end
      // Stack set inside RAM before first use
      wr(cprs_pkg::REG_SP, 20'h0FE20);
      sp = 16'hFE20;
      ps = 8'($urandom);
      wr(cprs_pkg::REG_PSW, 20'(ps));
      @(posedge clk_sys);
      push_status <= 1'b1;
      stk_q.push_back({sp - 16'h0001, ps});
      fin();
      sp = sp - 16'h0001;
      rd(cprs_pkg::REG_SP, 20'(sp));
      for (int i = 0; i < 5; i++) begin
         e = irq_t[i];
         wr(cprs_pkg::REG_PSW, 20'(e[8:1]));
         @(posedge clk_sys);
         irq_req <= 1'b1;
         irq_masked <= e[11];
         irq_prio <= e[10:9];
         if (e[0])
            stk_q.push_back({sp - 16'h0001, e[8:1]});
         fin();
         chk(24'(irq_ack), 24'(e[0]));
         ps = e[0] ? {1'b0, e[7:4], e[10:9], e[1]} : e[8:1];
         chk(24'(status_word), 24'(ps));
         sp = sp - 16'(e[0]);
      end
      irq_masked <= 1'b0;
      d = 8'($urandom);
      @(posedge clk_sys);
      restore_go <= 1'b1;
      restore_data <= d;
      fin();
      sp = sp + 16'h0001;
      chk(24'(status_word), 24'(d));
      rd(cprs_pkg::REG_SP, 20'(sp));
      wr(cprs_pkg::REG_MIRROR, 20'h00001);
      rd(cprs_pkg::REG_MIRROR, 20'h00001);
      chk(24'(mirror_active), 24'h000000);
      wr(cprs_pkg::REG_MIRROR, 20'h00000);
      rd(cprs_pkg::REG_MIRROR, 20'h00000);
      chk(24'(mirror_active), 24'h000001);
      settle();
      chk(24'(rd_q.size() + stk_q.size()), 24'h000000);
      give_verdict();
   end
endmodule
